// ---- verilog/link_ctrl_pkg.sv ----
// constants shared by the serial link status and lane control logic
package link_ctrl_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0]  IDX_LINK_STATE = 10'h208;
   localparam logic [9:0]  IDX_CHAN_PD    = 10'h209;
   localparam logic [9:0]  IDX_SPARE_A    = 10'h20A;
   localparam logic [9:0]  IDX_SPARE_B    = 10'h20B;
   localparam int          ADDR_W         = 12;
   localparam int          DATA_W         = 8;
   localparam int          LANES          = 8;
   // status field positions
   localparam int          ST_LINK_UP     = 6;
   localparam int          ST_SYNC        = 5;
   localparam int          ST_REALIGNED   = 4;
   localparam int          ST_ALIGNMENT_FLAG     = 3;
   localparam int          ST_PLL_LOCKED  = 2;
   // power-down field positions
   localparam int          PD_CHAN_A      = 0;
   localparam int          PD_CHAN_B      = 1;
   // spare lane register fields
   localparam int          SP_SER_BIT     = 0;
   // reset values
   localparam logic [7:0]  RST_CHAN_PD    = 8'h00;
   localparam logic [7:0]  RST_SPARE      = 8'h00;
   localparam logic [7:0]  RD_IDLE        = 8'h00;
endpackage

// ---- verilog/lane_gate.sv ----
// per-link lane clock and serializer enable gating
`timescale 1ns/1ps
module lane_gate
   import link_ctrl_pkg::*;
#(
   parameter int NLANES = LANES
)
(
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              resetn,
   // control
   input  wire logic              link_active,
   input  wire logic              spare_ser,
   input  wire logic [NLANES-1:0] base_lanes,
   input  wire logic [NLANES-1:1] spare_lanes,
   // enables
   output logic      [NLANES-1:0] lane_clk_en,
   output logic      [NLANES-1:0] ser_en
);
   typedef struct packed {
      logic [NLANES-1:0] lane_clk;
      logic [NLANES-1:0] ser;
   } gate_state_t;

   gate_state_t state_ff;
   gate_state_t nxt_state;
   logic [NLANES-1:0] lane_on;
   logic [NLANES-1:0] ser_want;
   logic [NLANES-1:0] chain;
   logic [NLANES-1:0] ser_ok;

   initial
   begin
      if (NLANES < 2 || NLANES > 8)
         $error("lane_gate: NLANES must be 2 to 8");
   end

   assign lane_on[0]  = base_lanes[0];
   assign ser_want[0] = base_lanes[0];
   assign chain[0]    = lane_on[0];
   assign ser_ok[0]   = ser_want[0];

   genvar n;
   generate
      for (n = 1; n < NLANES; n++)
      begin : g_lane
         // spare lane counts even where the mode leaves it unused
         assign lane_on[n]  = base_lanes[n] | spare_lanes[n];
         // spare serializers only with the serializer bit set
         assign ser_want[n] = base_lanes[n] |
                              (spare_lanes[n] & spare_ser);
         assign chain[n]    = chain[n-1] & lane_on[n];
         // no clock unless every lower lane is enabled
         assign ser_ok[n]   = ser_want[n] & chain[n-1];
      end
   endgenerate

   always_comb
   begin
      nxt_state          = state_ff;
      // spare lanes do not revive a powered-down link
      nxt_state.lane_clk = link_active ? lane_on : '0;
      nxt_state.ser      = link_active ? ser_ok : '0;
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

   assign lane_clk_en = state_ff.lane_clk;
   assign ser_en      = state_ff.ser;

   property p_ser_chain;
      @(posedge clk_sys) disable iff (!resetn)
      ser_en[NLANES-1] |-> &lane_clk_en[NLANES-2:0];
   endproperty
   a_ser_chain: assert property (p_ser_chain)
      else $error("top serializer clocked with a lower lane off");

   property p_dead_link;
      @(posedge clk_sys) disable iff (!resetn)
      !link_active |=> (lane_clk_en == '0 && ser_en == '0);
   endproperty
   a_dead_link: assert property (p_dead_link)
      else $error("lane enabled on an inactive link");

   property p_spare_clk;
      @(posedge clk_sys) disable iff (!resetn)
      (link_active && spare_lanes[1]) |=> lane_clk_en[1];
   endproperty
   a_spare_clk: assert property (p_spare_clk)
      else $error("spare lane clock not enabled");

   property p_spare_ser_off;
      @(posedge clk_sys) disable iff (!resetn)
      (!spare_ser && !base_lanes[1]) |=> !ser_en[1];
   endproperty
   a_spare_ser_off: assert property (p_spare_ser_off)
      else $error("spare serializer on without serializer bit");

   c_ser_chain: cover property (@(posedge clk_sys) disable iff (!resetn)
      ser_en[NLANES-1]);
endmodule

// ---- verilog/serial_link_status_power_lane_ctrl.sv ----
// serial link status, channel power-down and spare lane control
//
// Functional notes
// - status bit 6 shows link established; read only.
// - status bit 5 reads 0 while SYNC~ asserted, 1 otherwise.
// - status bit 4 sets on SYSREF clock realignment, sticky.
// - writing one clears the realignment flag; zero leaves it.
// - status bit 2 shows serializer PLL lock.
// - power-down bits 0 and 1 power ADC A and B; reset zero.
// - digital channels bound to a powered-down ADC power down too.
// - both ADCs down powers down whole serial subsystem and PLL.
// - link A keeps running when digital channel B is disabled.
// - per link, field bit n enables spare lane n, n one to seven.
// - spare lane enable acts even if the mode skips that lane.
// - spare lane bit turns on that lane's link-layer clocks.
// - serializer bit zero: clocks only; one: serializers transmit too.
// - spare lanes follow active link mode and test pattern selection.
// - powered-down link stays inactive despite spare lanes enabled.
// - serializer n clocked only when lanes 0 to n-1 are enabled.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module serial_link_status_power_lane_ctrl
   import link_ctrl_pkg::*;
#(
   parameter int NLANES = LANES
)
(
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              resetn,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   // link and clocking state
   input  wire logic              sync_req_n,
   input  wire logic              link_up,
   input  wire logic              pll_locked,
   input  wire logic              sysref_realign,
   input  wire logic              align_event,
   input  wire logic              link_enable,
   // mode and binding settings
   input  wire logic              bind_a_to_b,
   input  wire logic              bind_b_to_b,
   input  wire logic [3:0]        link_mode_select,
   input  wire logic [3:0]        test_pattern_select,
   input  wire logic [NLANES-1:0] mode_lanes_a,
   input  wire logic [NLANES-1:0] mode_lanes_b,
   // power control
   output logic                   power_down_chan_a,
   output logic                   power_down_chan_b,
   output logic                   dig_pd_a,
   output logic                   dig_pd_b,
   output logic                   serial_pd,
   output logic                   link_active_a,
   output logic                   link_active_b,
   // lane control
   output logic      [3:0]        lane_rate_mode,
   output logic      [3:0]        lane_pattern,
   output logic      [NLANES-1:0] lane_clk_en_a,
   output logic      [NLANES-1:0] ser_en_a,
   output logic      [NLANES-1:0] lane_clk_en_b,
   output logic      [NLANES-1:0] ser_en_b
);
   typedef struct packed {
      logic [1:0]        chan_pd;
      logic [NLANES-1:0] spare_a;
      logic [NLANES-1:0] spare_b;
      logic              realigned;
      logic              alignment_flag;
      logic [1:0]        sync_pipe;
      logic [DATA_W-1:0] rdata;
      logic              dig_pd_a;
      logic              dig_pd_b;
      logic              serial_pd;
      logic              active_a;
      logic              active_b;
      logic [3:0]        rate_mode;
      logic [3:0]        pattern;
   } ctrl_state_t;

   ctrl_state_t       state_ff;
   ctrl_state_t       nxt_state;
   logic [9:0]        idx;
   logic              alignment_flag_addr;
   logic [DATA_W-1:0] status_word;

   initial
   begin
      if (NLANES != 8)
         $error("serial link ctrl: register fields need NLANES of 8");
   end

   assign idx          = reg_addr[ADDR_W-1:2];
   assign alignment_flag_addr = (reg_addr[1:0] == 2'h0);

   // reserved bits read zero and hold no state
   always_comb
   begin
      status_word                = '0;
      status_word[ST_LINK_UP]    = link_up;
      status_word[ST_SYNC]       = state_ff.sync_pipe[1];
      status_word[ST_REALIGNED]  = state_ff.realigned;
      status_word[ST_ALIGNMENT_FLAG]    = state_ff.alignment_flag;
      status_word[ST_PLL_LOCKED] = pll_locked;
   end

   always_comb
   begin
      nxt_state = state_ff;
      // sync pin is asynchronous; second stage is the only reader
      nxt_state.sync_pipe = {state_ff.sync_pipe[0], sync_req_n};
      nxt_state.rdata     = RD_IDLE;
      if (reg_rd && alignment_flag_addr)
      begin
         case (idx)
            IDX_LINK_STATE: nxt_state.rdata = status_word;
            IDX_CHAN_PD:    nxt_state.rdata = {6'h00, state_ff.chan_pd};
            IDX_SPARE_A:    nxt_state.rdata = state_ff.spare_a;
            IDX_SPARE_B:    nxt_state.rdata = state_ff.spare_b;
            default:        nxt_state.rdata = RD_IDLE;
         endcase
      end
      if (reg_wr && alignment_flag_addr)
      begin
         case (idx)
            IDX_LINK_STATE:
            begin
               if (reg_wdata[ST_REALIGNED])
                  nxt_state.realigned = 1'b0;
               if (reg_wdata[ST_ALIGNMENT_FLAG])
                  nxt_state.alignment_flag = 1'b0;
            end
            // driving these with link enabled is the caller's fault
            IDX_CHAN_PD: nxt_state.chan_pd = reg_wdata[1:0];
            IDX_SPARE_A: nxt_state.spare_a = reg_wdata;
            IDX_SPARE_B: nxt_state.spare_b = reg_wdata;
            default:     nxt_state.chan_pd = state_ff.chan_pd;
         endcase
      end
      // an event in the clearing cycle wins over the clear
      if (sysref_realign)
         nxt_state.realigned = 1'b1;
      if (align_event)
         nxt_state.alignment_flag = 1'b1;
      // digital channels follow the ADC they are bound to
      nxt_state.dig_pd_a = bind_a_to_b ? state_ff.chan_pd[PD_CHAN_B]
                                       : state_ff.chan_pd[PD_CHAN_A];
      nxt_state.dig_pd_b = bind_b_to_b ? state_ff.chan_pd[PD_CHAN_B]
                                       : state_ff.chan_pd[PD_CHAN_A];
      nxt_state.serial_pd = &state_ff.chan_pd;
      // link A depends on its own channel only, so B may drop out
      nxt_state.active_a = link_enable && !nxt_state.dig_pd_a &&
                           !nxt_state.serial_pd;
      nxt_state.active_b = link_enable && !nxt_state.dig_pd_b &&
                           !nxt_state.serial_pd;
      nxt_state.rate_mode = link_mode_select;
      nxt_state.pattern   = test_pattern_select;
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         state_ff           <= '0;
         state_ff.chan_pd   <= RST_CHAN_PD[1:0];
         state_ff.spare_a   <= RST_SPARE;
         state_ff.spare_b   <= RST_SPARE;
         state_ff.sync_pipe <= 2'h3;
      end
      else
         state_ff <= nxt_state;
   end

   lane_gate #(
      .NLANES      (NLANES)
   ) u_lane_a (
      .clk_sys     (clk_sys),
      .resetn      (resetn),
      .link_active (state_ff.active_a),
      .spare_ser   (state_ff.spare_a[SP_SER_BIT]),
      .base_lanes  (mode_lanes_a),
      .spare_lanes (state_ff.spare_a[NLANES-1:1]),
      .lane_clk_en (lane_clk_en_a),
      .ser_en      (ser_en_a)
   );

   lane_gate #(
      .NLANES      (NLANES)
   ) u_lane_b (
      .clk_sys     (clk_sys),
      .resetn      (resetn),
      .link_active (state_ff.active_b),
      .spare_ser   (state_ff.spare_b[SP_SER_BIT]),
      .base_lanes  (mode_lanes_b),
      .spare_lanes (state_ff.spare_b[NLANES-1:1]),
      .lane_clk_en (lane_clk_en_b),
      .ser_en      (ser_en_b)
   );

   assign reg_rdata         = state_ff.rdata;
   assign power_down_chan_a = state_ff.chan_pd[PD_CHAN_A];
   assign power_down_chan_b = state_ff.chan_pd[PD_CHAN_B];
   assign dig_pd_a          = state_ff.dig_pd_a;
   assign dig_pd_b          = state_ff.dig_pd_b;
   assign serial_pd         = state_ff.serial_pd;
   assign link_active_a     = state_ff.active_a;
   assign link_active_b     = state_ff.active_b;
   assign lane_rate_mode    = state_ff.rate_mode;
   assign lane_pattern      = state_ff.pattern;

   property p_rd_status;
      @(posedge clk_sys) disable iff (!resetn)
      (reg_rd && reg_addr == {IDX_LINK_STATE, 2'h0})
      |=> (reg_rdata[ST_LINK_UP] == $past(link_up) &&
           reg_rdata[ST_PLL_LOCKED] == $past(pll_locked) &&
           reg_rdata[7] == 1'b0 && reg_rdata[1:0] == 2'h0);
   endproperty
   a_rd_status: assert property (p_rd_status)
      else $error("status read does not match link and lock state");

   property p_sync_follow;
      @(posedge clk_sys) disable iff (!resetn)
      $fell(sync_req_n) ##1 !sync_req_n |=> !state_ff.sync_pipe[1];
   endproperty
   a_sync_follow: assert property (p_sync_follow)
      else $error("sync status missed an asserted request");

   property p_sync_high;
      @(posedge clk_sys) disable iff (!resetn)
      $rose(sync_req_n) ##1 sync_req_n |=> state_ff.sync_pipe[1];
   endproperty
   a_sync_high: assert property (p_sync_high)
      else $error("sync status missed a released request");

   property p_realign_set;
      @(posedge clk_sys) disable iff (!resetn)
      sysref_realign |=> state_ff.realigned;
   endproperty
   a_realign_set: assert property (p_realign_set)
      else $error("realignment flag not set by its event");

   property p_realign_hold;
      @(posedge clk_sys) disable iff (!resetn)
      (state_ff.realigned && !(reg_wr && reg_wdata[ST_REALIGNED]))
      |=> state_ff.realigned;
   endproperty
   a_realign_hold: assert property (p_realign_hold)
      else $error("realignment flag dropped without a clear");

   property p_realign_clr;
      @(posedge clk_sys) disable iff (!resetn)
      (reg_wr && reg_addr == {IDX_LINK_STATE, 2'h0} &&
       reg_wdata[ST_REALIGNED] && !sysref_realign)
      |=> !state_ff.realigned;
   endproperty
   a_realign_clr: assert property (p_realign_clr)
      else $error("write one did not clear realignment flag");

   property p_realign_keep;
      @(posedge clk_sys) disable iff (!resetn)
      (state_ff.realigned && reg_wr && !reg_wdata[ST_REALIGNED])
      |=> state_ff.realigned;
   endproperty
   a_realign_keep: assert property (p_realign_keep)
      else $error("write zero disturbed realignment flag");

   property p_alignment_flag_clr;
      @(posedge clk_sys) disable iff (!resetn)
      (reg_wr && reg_addr == {IDX_LINK_STATE, 2'h0} &&
       reg_wdata[ST_ALIGNMENT_FLAG] && !align_event) |=> !state_ff.alignment_flag;
   endproperty
   a_alignment_flag_clr: assert property (p_alignment_flag_clr)
      else $error("alignment flag not cleared");

   property p_alignment_flag_set;
      @(posedge clk_sys) disable iff (!resetn)
      align_event |=> state_ff.alignment_flag;
   endproperty
   a_alignment_flag_set: assert property (p_alignment_flag_set)
      else $error("alignment flag not set by its event");

   property p_pd_write;
      @(posedge clk_sys) disable iff (!resetn)
      (reg_wr && reg_addr == {IDX_CHAN_PD, 2'h0})
      |=> {power_down_chan_b, power_down_chan_a} == $past(reg_wdata[1:0]);
   endproperty
   a_pd_write: assert property (p_pd_write)
      else $error("channel power-down write not applied");

   property p_bind;
      @(posedge clk_sys) disable iff (!resetn)
      (!bind_a_to_b && power_down_chan_a) |=> dig_pd_a;
   endproperty
   a_bind: assert property (p_bind)
      else $error("bound digital channel stayed powered");

   property p_bind_b;
      @(posedge clk_sys) disable iff (!resetn)
      (bind_b_to_b && power_down_chan_b) |=> dig_pd_b;
   endproperty
   a_bind_b: assert property (p_bind_b)
      else $error("digital channel B stayed powered");

   property p_all_down;
      @(posedge clk_sys) disable iff (!resetn)
      (power_down_chan_a && power_down_chan_b)
      |=> (serial_pd && !link_active_a && !link_active_b);
   endproperty
   a_all_down: assert property (p_all_down)
      else $error("serial subsystem not powered down");

   property p_link_a_alone;
      @(posedge clk_sys) disable iff (!resetn)
      // channel B may be down; link A needs only its own ADC
      (link_enable && !bind_a_to_b && !power_down_chan_a)
      |=> link_active_a;
   endproperty
   a_link_a_alone: assert property (p_link_a_alone)
      else $error("link A dropped though its channel is powered");

   property p_chan_down;
      @(posedge clk_sys) disable iff (!resetn)
      (link_enable && !bind_a_to_b && power_down_chan_a)
      |=> !link_active_a;
   endproperty
   a_chan_down: assert property (p_chan_down)
      else $error("link A active with its channel powered down");

   property p_spare_rd;
      @(posedge clk_sys) disable iff (!resetn)
      (reg_wr && reg_addr == {IDX_SPARE_A, 2'h0}) ##1 !reg_wr ##1
      (reg_rd && reg_addr == {IDX_SPARE_A, 2'h0})
      |=> reg_rdata == $past(reg_wdata, 3);
   endproperty
   a_spare_rd: assert property (p_spare_rd)
      else $error("spare lane register read back wrong");

   c_realign: cover property (@(posedge clk_sys) disable iff (!resetn)
      sysref_realign ##[1:20] (reg_wr && reg_wdata[ST_REALIGNED]));
   c_all_down: cover property (@(posedge clk_sys) disable iff (!resetn)
      serial_pd);
   c_spare_tx: cover property (@(posedge clk_sys) disable iff (!resetn)
      ser_en_a[7] && link_active_a);
endmodule

// ---- test/link_rx_model.sv ----
// behavioural receiver at the far end of the serial links
`timescale 1ns/1ps
module link_rx_model
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic resetn,
   // device side state
   input  wire logic link_run,
   input  wire logic serial_pd,
   input  wire logic slow,
   // receiver outputs
   output logic      sync_req_n,
   output logic      link_up,
   output logic      pll_locked
);
   logic [5:0] lock_cnt;
   logic [5:0] sync_cnt;
   logic [5:0] lock_lim;
   logic [5:0] sync_lim;

   // slow mode stretches both lock and code group sync phases
   assign lock_lim = slow ? 6'h0C : 6'h03;
   assign sync_lim = slow ? 6'h0A : 6'h02;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         lock_cnt <= 6'h00;
         sync_cnt <= 6'h00;
      end
      else
      begin
         // lock is lost at once when the serial side powers down
         if (serial_pd)
            lock_cnt <= 6'h00;
         else if (lock_cnt != 6'h3F)
            lock_cnt <= lock_cnt + 6'h01;
         if (!(link_run && pll_locked))
            sync_cnt <= 6'h00;
         else if (sync_cnt != 6'h3F)
            sync_cnt <= sync_cnt + 6'h01;
      end
   end

   assign pll_locked = lock_cnt >= lock_lim;
   // request held low until the link has settled
   assign sync_req_n = !(link_run && sync_cnt < sync_lim);
   assign link_up    = link_run && sync_cnt >= sync_lim;
endmodule

// ---- test/testbench.sv ----
// self-checking bench for the link status and lane control block
`timescale 1ns/1ps
module testbench;
   import link_ctrl_pkg::*;
   localparam logic [11:0] A_ST = {IDX_LINK_STATE, 2'b00};
   localparam logic [11:0] A_PD = {IDX_CHAN_PD, 2'b00};
   localparam logic [11:0] A_SA = {IDX_SPARE_A, 2'b00};
   localparam logic [11:0] A_SB = {IDX_SPARE_B, 2'b00};
   logic        clk_sys, resetn, reg_wr, reg_rd, slow, link_run;
   logic [11:0] reg_addr;
   logic [7:0]  reg_wdata, reg_rdata;
   logic        sync_req_n, link_up, pll_locked, sysref_realign;
   logic        align_event, link_enable, bind_a_to_b, bind_b_to_b;
   logic [3:0]  link_mode_select, test_pattern_select;
   logic [3:0]  lane_rate_mode, lane_pattern;
   logic [7:0]  mode_lanes_a, mode_lanes_b;
   logic        power_down_chan_a, power_down_chan_b, dig_pd_a, dig_pd_b;
   logic        serial_pd, link_active_a, link_active_b;
   logic [7:0]  lane_clk_en_a, ser_en_a, lane_clk_en_b, ser_en_b;
   int          errors, n_checks, i;
   integer      seed;
   logic [31:0] r;
   logic [1:0]  pd;
   logic [7:0]  sa, sb;
   logic        rf, af;

   serial_link_status_power_lane_ctrl i_serial_link_status_power_lane_ctrl (
      .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .sync_req_n(sync_req_n), .link_up(link_up),
      .pll_locked(pll_locked), .sysref_realign(sysref_realign),
      .align_event(align_event), .link_enable(link_enable),
      .bind_a_to_b(bind_a_to_b), .bind_b_to_b(bind_b_to_b),
      .link_mode_select(link_mode_select),
      .test_pattern_select(test_pattern_select),
      .mode_lanes_a(mode_lanes_a), .mode_lanes_b(mode_lanes_b),
      .power_down_chan_a(power_down_chan_a),
      .power_down_chan_b(power_down_chan_b), .dig_pd_a(dig_pd_a),
      .dig_pd_b(dig_pd_b), .serial_pd(serial_pd),
      .link_active_a(link_active_a), .link_active_b(link_active_b),
      .lane_rate_mode(lane_rate_mode), .lane_pattern(lane_pattern),
      .lane_clk_en_a(lane_clk_en_a), .ser_en_a(ser_en_a),
      .lane_clk_en_b(lane_clk_en_b), .ser_en_b(ser_en_b));

   assign link_run = link_active_a | link_active_b;
   link_rx_model i_link_rx_model (
      .clk_sys(clk_sys), .resetn(resetn), .link_run(link_run),
      .serial_pd(serial_pd), .slow(slow), .sync_req_n(sync_req_n),
      .link_up(link_up), .pll_locked(pll_locked));

   always #50 clk_sys = ~clk_sys;

   task automatic complete_run;
      if (errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // callers enter right after a rising edge
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      // idle edge so a following write never re-raises the strobe at once
      @(posedge clk_sys);
   endtask

   // data are sampled mid-cycle, inside their only valid cycle
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      @(negedge clk_sys);
      chk(16'(reg_rdata), 16'(exp));
      @(posedge clk_sys);
   endtask

   function automatic logic [7:0] st_exp();
      return {1'b0, link_up, sync_req_n, rf, af, pll_locked, 2'b00};
   endfunction

   // returns serializer enables above lane clock enables
   function automatic logic [15:0] lanes_exp(input logic act,
      input logic [7:0] m, input logic [7:0] s);
      logic [7:0] c, q;
      logic       lower, e;
      lower = 1'b1;
      for (int n = 0; n < 8; n++)
      begin
         e     = m[n] | (n > 0 && s[n]);
         c[n]  = act & e;
         q[n]  = act & lower & (m[n] | (n > 0 && s[n] && s[0]));
         lower = lower & e;
      end
      return {q, c};
   endfunction

   task automatic chk_out;
      logic da, db, sp, aa, ab;
      da = bind_a_to_b ? pd[1] : pd[0];
      db = bind_b_to_b ? pd[1] : pd[0];
      sp = pd[0] & pd[1];
      aa = link_enable & !da & !sp;
      ab = link_enable & !db & !sp;
      chk(16'({power_down_chan_b, power_down_chan_a}), 16'(pd));
      chk(16'({dig_pd_b, dig_pd_a}), 16'({db, da}));
      chk(16'(serial_pd), 16'(sp));
      chk(16'({link_active_b, link_active_a}), 16'({ab, aa}));
      chk({ser_en_a, lane_clk_en_a}, lanes_exp(aa, mode_lanes_a, sa));
      chk({ser_en_b, lane_clk_en_b}, lanes_exp(ab, mode_lanes_b, sb));
      chk(16'({lane_pattern, lane_rate_mode}),
          16'({test_pattern_select, link_mode_select}));
   endtask

   initial
   begin
      repeat (100000) @(posedge clk_sys);
      errors++;
      complete_run();
   end

   initial
   begin
      clk_sys = 1'b0;
      resetn = 1'b0;
      {reg_wr, reg_rd, sysref_realign, align_event, link_enable} = 5'h00;
      {bind_a_to_b, bind_b_to_b, slow} = 3'h0;
      reg_addr = 12'h000;
      reg_wdata = 8'h00;
      {link_mode_select, test_pattern_select} = 8'h00;
      mode_lanes_a = 8'h01;
      mode_lanes_b = 8'h01;
      errors = 0;
      n_checks = 0;
      seed = 32'hb466a2e3;
      pd = 2'b00;
      sa = 8'h00;
      sb = 8'h00;
      rf = 1'b0;
      af = 1'b0;
      repeat (5) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      chk_out();
      rd(A_PD, RST_CHAN_PD);
      rd(A_SA, RST_SPARE);
      rd(A_SB, RST_SPARE);
      // misaligned write must not land, unmapped read gives idle
      wr(A_PD + 12'h001, 8'h03);
      rd(A_PD + 12'h001, RD_IDLE);
      rd(12'h840, RD_IDLE);
      rd(A_PD, 8'h00);
      // read data must not outlive their one cycle
      @(negedge clk_sys);
      chk(16'(reg_rdata), 16'(RD_IDLE));
      repeat (10) @(posedge clk_sys);
      rd(A_ST, st_exp());
      sysref_realign <= 1'b1;
      @(posedge clk_sys);
      sysref_realign <= 1'b0;
      rf = 1'b1;
      rd(A_ST, st_exp());
      align_event <= 1'b1;
      @(posedge clk_sys);
      align_event <= 1'b0;
      af = 1'b1;
      wr(A_ST, 8'hE7);
      rd(A_ST, st_exp());
      wr(A_ST, 8'h10);
      rf = 1'b0;
      rd(A_ST, st_exp());
      wr(A_ST, 8'h08);
      af = 1'b0;
      rd(A_ST, st_exp());
      for (i = 0; i < 30; i++)
      begin
         link_enable <= 1'b0;
         @(posedge clk_sys);
         r = $random(seed);
         pd = r[1:0];
         // a both-down draw stands in for the global mode shutdown
         wr(A_PD, r[7:0]);
         sa = 8'($random(seed));
         wr(A_SA, sa);
         rd(A_SA, sa);
         sb = 8'($random(seed));
         wr(A_SB, sb);
         r = $random(seed);
         bind_a_to_b <= r[0];
         bind_b_to_b <= r[1];
         slow <= r[2];
         mode_lanes_a <= r[15:8];
         mode_lanes_b <= r[23:16];
         link_mode_select <= r[27:24];
         test_pattern_select <= r[31:28];
         link_enable <= r[3] | r[4];
         repeat (40) @(posedge clk_sys);
         chk_out();
         rd(A_PD, {6'h00, pd});
         rd(A_SA, sa);
         rd(A_SB, sb);
         rd(A_ST, st_exp());
      end
      complete_run();
   end
endmodule
